/* sgpc_pkg.sv */
package sgpc_pkg;

  // bus geometry
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control register fields
  localparam int unsigned CTRL_SELECT_BIT = 0;
  localparam int unsigned CTRL_SELFTEST_BIT = 1;
  localparam logic CTRL_SELECT_RESET = 1'b0;

  // status register fields
  localparam int unsigned STAT_BOARD_LSB = 0;
  localparam int unsigned STAT_CHOSEN_BIT = 8;
  localparam int unsigned STAT_BYPASS_BIT = 9;
  localparam int unsigned STAT_PORTSEL_LSB = 10;
  localparam int unsigned STAT_SELFTEST_BIT = 13;
  localparam int unsigned STAT_TRST_BIT = 14;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing, least pulse widths round up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TRST_PULSE_NS = 1000;
  localparam int unsigned SELFTEST_PULSE_NS = 1000;
  localparam int unsigned TRST_PULSE_CYC = (TRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SELFTEST_PULSE_CYC =
    (SELFTEST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CNT_W = 16;

  // board status width
  localparam int unsigned STATUS_W = 8;

  // idle levels of a driven local port
  localparam logic PORT_TMS_IDLE = 1'b1;
  localparam logic PORT_TDO_IDLE = 1'b1;

  // one local scan port as driven by the gateway
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdo;
    logic trst_n;
  } sgpc_port_s;

endpackage

/* sgpc_gateway.sv */
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sgpc_gateway #(
  parameter int unsigned NUM_PORTS = 6,
  parameter int unsigned SEL_W = 3
) (
  // system clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // axi4-lite write address and data
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [sgpc_pkg::AXI_ADDR_W-1:0] awaddr_in,
  input wire logic [2:0] awprot_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [sgpc_pkg::AXI_DATA_W-1:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // axi4-lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // axi4-lite read
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [sgpc_pkg::AXI_ADDR_W-1:0] araddr_in,
  input wire logic [2:0] arprot_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [sgpc_pkg::AXI_DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  // primary scan bus, link clock domain
  input wire logic upstream_tck_in,
  input wire logic upstream_tms_in,
  input wire logic upstream_tdi_in,
  input wire logic upstream_trst_n_in,
  output logic upstream_tdo_out,
  output logic upstream_tdo_oe_n_out,
  // board pins
  input wire logic lsp_reset_n_in,
  input wire logic toe_n_in,
  input wire logic bypass_route_en_n_in,
  input wire logic [SEL_W-1:0] bypass_port_select_in,
  input wire logic [sgpc_pkg::STATUS_W-1:0] board_status_in,
  output logic gateway_chosen_n_out,
  output logic local_enable_n_out,
  output logic self_test_n_out,
  // local scan ports
  output sgpc_pkg::sgpc_port_s [NUM_PORTS-1:0] local_port_out,
  output logic [NUM_PORTS-1:0] local_port_oe_n_out,
  input wire logic [NUM_PORTS-1:0] local_port_tdi_in,
  output logic [NUM_PORTS-1:0] port_debug_enable_n_out
);

  // refuse geometries the select decoder cannot serve
  if (NUM_PORTS < 1 || NUM_PORTS > (1 << SEL_W) || SEL_W > 3)
  begin : g_bad_geometry
    $error("sgpc_gateway: port count does not fit select width");
  end

  // pin synchronisers into the system domain
  logic lsp_reset_n_s1_q, lsp_reset_n_s2_q;
  logic toe_n_s1_q, toe_n_s2_q;
  logic byp_en_n_s1_q, byp_en_n_s2_q;
  logic [SEL_W-1:0] byp_sel_s1_q, byp_sel_s2_q;
  logic [sgpc_pkg::STATUS_W-1:0] status_s1_q, status_s2_q;
  // control and pulse state
  logic chosen_q;
  logic lsp_reset_n_prev_q;
  logic [sgpc_pkg::PULSE_CNT_W-1:0] trst_cnt_q;
  logic [sgpc_pkg::PULSE_CNT_W-1:0] selftest_cnt_q;
  logic selftest_go;
  logic trst_start;
  // routing state
  logic bypass_on;
  logic [NUM_PORTS-1:0] routed_q;
  logic [NUM_PORTS-1:0] port_oe_n_q;
  logic [NUM_PORTS-1:0] debug_en_n_q;
  logic tdo_oe_n_q;
  logic bypass_on_q;
  logic [SEL_W-1:0] route_sel_q;
  // axi state
  logic aw_held_q, w_held_q;
  logic [sgpc_pkg::AXI_ADDR_W-1:0] awaddr_q;
  logic [sgpc_pkg::AXI_DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [sgpc_pkg::AXI_DATA_W-1:0] rdata_q;
  logic do_write;
  logic [sgpc_pkg::AXI_DATA_W-1:0] status_word;
  // link domain state
  logic chosen_l1_q, chosen_l2_q;
  logic [sgpc_pkg::STATUS_W-1:0] status_l1_q, status_l2_q;
  logic [sgpc_pkg::STATUS_W-1:0] shift_q;

  // two flops on every board pin before any logic looks at it
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      lsp_reset_n_s1_q <= 1'b1;
      lsp_reset_n_s2_q <= 1'b1;
      toe_n_s1_q <= 1'b0;
      toe_n_s2_q <= 1'b0;
      byp_en_n_s1_q <= 1'b1;
      byp_en_n_s2_q <= 1'b1;
      byp_sel_s1_q <= '0;
      byp_sel_s2_q <= '0;
      status_s1_q <= '0;
      status_s2_q <= '0;
    end
    else if (ce_in)
    begin
      lsp_reset_n_s1_q <= lsp_reset_n_in;
      lsp_reset_n_s2_q <= lsp_reset_n_s1_q;
      toe_n_s1_q <= toe_n_in;
      toe_n_s2_q <= toe_n_s1_q;
      byp_en_n_s1_q <= bypass_route_en_n_in;
      byp_en_n_s2_q <= byp_en_n_s1_q;
      byp_sel_s1_q <= bypass_port_select_in;
      byp_sel_s2_q <= byp_sel_s1_q;
      status_s1_q <= board_status_in;
      status_s2_q <= status_s1_q;
    end
  end

  // axi write: address and data taken in either order
  assign awready_out = !aw_held_q && !bvalid_q;
  assign wready_out = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= sgpc_pkg::RESP_OKAY;
    end
    else if (ce_in)
    begin
      if (awvalid_in && awready_out)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= awaddr_in;
      end
      if (wvalid_in && wready_out)
      begin
        w_held_q <= 1'b1;
        wdata_q <= wdata_in;
        wstrb_q <= wstrb_in;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == sgpc_pkg::CTRL_OFFSET || awaddr_q == sgpc_pkg::STATUS_OFFSET)
                   ? sgpc_pkg::RESP_OKAY : sgpc_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && bready_in)
        bvalid_q <= 1'b0;
    end
  end

  // self-test command is a write of one to the go bit, lane 0 only
  assign selftest_go = do_write && awaddr_q == sgpc_pkg::CTRL_OFFSET && wstrb_q[0]
                       && wdata_q[sgpc_pkg::CTRL_SELFTEST_BIT];
  // falling edge of the synced local reset starts the trst pulse
  assign trst_start = lsp_reset_n_prev_q && !lsp_reset_n_s2_q;

  // selection flag, stands in for the address match on the scan bus
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      chosen_q <= sgpc_pkg::CTRL_SELECT_RESET;
      lsp_reset_n_prev_q <= 1'b1;
    end
    else if (ce_in)
    begin
      lsp_reset_n_prev_q <= lsp_reset_n_s2_q;
      if (!lsp_reset_n_s2_q)
        chosen_q <= 1'b0;
      else if (do_write && awaddr_q == sgpc_pkg::CTRL_OFFSET && wstrb_q[0])
        chosen_q <= wdata_q[sgpc_pkg::CTRL_SELECT_BIT];
    end
  end

  // trst pulse timer, restarted by each new local reset
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      trst_cnt_q <= '0;
    else if (ce_in)
    begin
      if (trst_start)
        trst_cnt_q <= sgpc_pkg::PULSE_CNT_W'(sgpc_pkg::TRST_PULSE_CYC);
      else if (trst_cnt_q != '0)
        trst_cnt_q <= trst_cnt_q - 1'b1;
    end
  end

  // self-test timer; a command during a pulse is absorbed, one pulse only
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      selftest_cnt_q <= '0;
    else if (ce_in)
    begin
      if (selftest_go && selftest_cnt_q == '0)
        selftest_cnt_q <= sgpc_pkg::PULSE_CNT_W'(sgpc_pkg::SELFTEST_PULSE_CYC);
      else if (selftest_cnt_q != '0)
        selftest_cnt_q <= selftest_cnt_q - 1'b1;
    end
  end

  // bypass decode from synced pins
  assign bypass_on = !byp_en_n_s2_q;

  // per-port routing, enables and debug enables
  for (genvar gi = 0; gi < NUM_PORTS; gi++)
  begin : g_port
    always_ff @(posedge sys_clk_in)
    begin
      if (reset_in)
      begin
        routed_q[gi] <= 1'b0;
        port_oe_n_q[gi] <= 1'b1;
        debug_en_n_q[gi] <= 1'b1;
      end
      else if (ce_in)
      begin
        // codes past the last port match no index, so nothing is routed
        routed_q[gi] <= bypass_on && byp_sel_s2_q == SEL_W'(gi);
        debug_en_n_q[gi] <= !(bypass_on && byp_sel_s2_q == SEL_W'(gi));
        // output enable pin overrides both routing and the trst pulse
        port_oe_n_q[gi] <= !(toe_n_s2_q
                             && ((bypass_on && byp_sel_s2_q == SEL_W'(gi))
                                 || trst_start || trst_cnt_q > 1));
      end
    end
    // straight wires keep the primary-to-port delay short
    always_comb
    begin
      local_port_out[gi].tck = upstream_tck_in;
      local_port_out[gi].tms = routed_q[gi] ? upstream_tms_in : sgpc_pkg::PORT_TMS_IDLE;
      local_port_out[gi].tdo = routed_q[gi] ? upstream_tdi_in : sgpc_pkg::PORT_TDO_IDLE;
      local_port_out[gi].trst_n = (trst_cnt_q != '0) ? 1'b0 : upstream_trst_n_in;
    end
  end

  // upstream data out enable and route register
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      tdo_oe_n_q <= 1'b1;
      bypass_on_q <= 1'b0;
      route_sel_q <= '0;
    end
    else if (ce_in)
    begin
      tdo_oe_n_q <= !(chosen_q || bypass_on);
      bypass_on_q <= bypass_on && byp_sel_s2_q < SEL_W'(NUM_PORTS);
      route_sel_q <= byp_sel_s2_q;
    end
  end

  // link domain: selection and board status cross by two flops
  always_ff @(posedge upstream_tck_in)
  begin
    chosen_l1_q <= chosen_q;
    chosen_l2_q <= chosen_l1_q;
    status_l1_q <= board_status_in;
    status_l2_q <= status_l1_q;
  end

  // status shifter: tms high captures, tms low shifts lsb first
  always_ff @(posedge upstream_tck_in)
  begin
    if (!upstream_trst_n_in)
      shift_q <= '0;
    else if (!chosen_l2_q)
      shift_q <= '0; // idle shifter leaves board pins untouched
    else if (upstream_tms_in)
      shift_q <= status_l2_q;
    else
      shift_q <= {1'b0, shift_q[sgpc_pkg::STATUS_W-1:1]};
  end

  // upstream data: routed port in bypass with a select code below NUM_PORTS, else the status shifter
  assign upstream_tdo_out = bypass_on_q ? local_port_tdi_in[route_sel_q] : shift_q[0];
  assign upstream_tdo_oe_n_out = tdo_oe_n_q;

  // axi read: single register stage, unmapped reads give slverr and zero
  assign status_word = {17'h00000,
                        trst_cnt_q != '0,
                        selftest_cnt_q != '0,
                        byp_sel_s2_q,
                        bypass_on,
                        chosen_q,
                        status_s2_q};
  assign arready_out = !rvalid_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= sgpc_pkg::RESP_OKAY;
    end
    else if (ce_in)
    begin
      if (arvalid_in && arready_out)
      begin
        rvalid_q <= 1'b1;
        if (araddr_in == sgpc_pkg::CTRL_OFFSET)
        begin
          rdata_q <= {31'h00000000, chosen_q};
          rresp_q <= sgpc_pkg::RESP_OKAY;
        end
        else if (araddr_in == sgpc_pkg::STATUS_OFFSET)
        begin
          rdata_q <= status_word;
          rresp_q <= sgpc_pkg::RESP_OKAY;
        end
        else
        begin
          rdata_q <= '0;
          rresp_q <= sgpc_pkg::RESP_SLVERR;
        end
      end
      else if (rvalid_q && rready_in)
        rvalid_q <= 1'b0;
    end
  end

  // bus and pin outputs
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;
  assign gateway_chosen_n_out = !chosen_q;
  assign local_enable_n_out = !chosen_q;
  assign self_test_n_out = (selftest_cnt_q == '0);
  assign local_port_oe_n_out = port_oe_n_q;
  assign port_debug_enable_n_out = debug_en_n_q;

endmodule

/* sgpc_gateway_monitor.sv */
`timescale 1ns/1ps
// pin-level watcher for the gateway
module sgpc_gateway_monitor #(
  parameter int unsigned NUM_PORTS = 6,
  parameter int unsigned SEL_W = 3
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // board pins
  input wire logic lsp_reset_n_in,
  input wire logic toe_n_in,
  input wire logic bypass_route_en_n_in,
  input wire logic [SEL_W-1:0] bypass_port_select_in,
  input wire logic upstream_tms_in,
  input wire logic gateway_chosen_n_out,
  input wire logic local_enable_n_out,
  input wire logic self_test_n_out,
  input wire logic upstream_tdo_oe_n_out,
  // local ports
  input wire sgpc_pkg::sgpc_port_s [NUM_PORTS-1:0] local_port_out,
  input wire logic [NUM_PORTS-1:0] local_port_oe_n_out,
  input wire logic [NUM_PORTS-1:0] port_debug_enable_n_out
);
  logic [7:0] low_cnt_q;
  // self-test low time, saturating so a stuck pin cannot wrap to a match
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || self_test_n_out)
      low_cnt_q <= 8'h00;
    else if (low_cnt_q != 8'hff)
      low_cnt_q <= low_cnt_q + 8'h01;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // pins held long enough to pass the synchronisers
  sequence s_bypass_held;
    (!bypass_route_en_n_in && toe_n_in && $stable(bypass_port_select_in))[*4];
  endsequence
  property p_idle;
    $fell(reset_in) |-> gateway_chosen_n_out && self_test_n_out &&
      (&port_debug_enable_n_out) && (&local_port_oe_n_out);
  endproperty
  a_idle: assert property (p_idle) else $error("outputs not idle after reset");
  property p_pair;
    local_enable_n_out == gateway_chosen_n_out;
  endproperty
  a_pair: assert property (p_pair) else $error("enable differs from chosen");
  property p_lsp;
    $fell(lsp_reset_n_in) && toe_n_in |-> ##[2:6] (local_port_oe_n_out == '0 &&
      !local_port_out[0].trst_n && !local_port_out[NUM_PORTS-1].trst_n && gateway_chosen_n_out);
  endproperty
  a_lsp: assert property (p_lsp) else $error("no trst pulse after local reset");
  property p_st_len;
    $rose(self_test_n_out) |-> low_cnt_q == 8'h64;
  endproperty
  a_st_len: assert property (p_st_len) else $error("self-test pulse length wrong");
  property p_route;
    s_bypass_held |-> ((bypass_port_select_in < NUM_PORTS) ?
      (!port_debug_enable_n_out[bypass_port_select_in] &&
      !local_port_oe_n_out[bypass_port_select_in] &&
      local_port_out[bypass_port_select_in].tms == upstream_tms_in) :
      ((&port_debug_enable_n_out) && (&local_port_oe_n_out)));
  endproperty
  a_route: assert property (p_route) else $error("bypass routing wrong");
  property p_onehot;
    $onehot0(~port_debug_enable_n_out);
  endproperty
  a_onehot: assert property (p_onehot) else $error("several debug enables low");
  property p_off;
    bypass_route_en_n_in[*4] |-> &port_debug_enable_n_out;
  endproperty
  a_off: assert property (p_off) else $error("debug enable low with bypass off");
  property p_toe;
    (!toe_n_in)[*4] |-> &local_port_oe_n_out;
  endproperty
  a_toe: assert property (p_toe) else $error("port driven while outputs disabled");
  property p_tdo;
    bypass_route_en_n_in[*4] ##0 gateway_chosen_n_out[*2] |-> upstream_tdo_oe_n_out;
  endproperty
  a_tdo: assert property (p_tdo) else $error("data out driven when unselected");
endmodule
bind sgpc_gateway sgpc_gateway_monitor #(.NUM_PORTS(NUM_PORTS), .SEL_W(SEL_W)) u_monitor (
  .sys_clk_in, .reset_in, .lsp_reset_n_in, .toe_n_in, .bypass_route_en_n_in,
  .bypass_port_select_in, .upstream_tms_in, .gateway_chosen_n_out, .local_enable_n_out,
  .self_test_n_out, .upstream_tdo_oe_n_out, .local_port_out, .local_port_oe_n_out,
  .port_debug_enable_n_out);

/* sgpc_scan_master.sv */
`timescale 1ns/1ps
// backplane test master; tck stands low between frames
module sgpc_scan_master (
  // scan bus towards the gateway
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_n_out,
  // data back from the gateway
  input wire logic tdo_in
);
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b0;
    tdi_out = 1'b0;
    trst_n_out = 1'b1;
  end
  // one 125 ns period; tdi toggles so stale data never looks valid
  task automatic tick(input logic mode);
    tms_out = mode;
    tdi_out = ~tdi_out;
    #62.5 tck_out = 1'b1;
    #62.5 tck_out = 1'b0;
  endtask
  // idle ticks let selection cross, then capture and shift lsb first
  task automatic read_status(output logic [7:0] v);
    #3.1;
    repeat (3) tick(1'b0);
    tick(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      v[i] = tdo_in;
      tick(1'b0);
    end
  endtask
endmodule

/* scan_gateway_pin_control_tb.sv */
`timescale 1ns/1ps
// board pins, register bus and scan master around one gateway
module scan_gateway_pin_control_tb;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ce_in = 1'b1;
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00, board_status_in = 8'ha5;
  logic [31:0] wdata_in = 32'h0;
  logic [2:0] awprot_in = 3'h0, arprot_in = 3'h0, bypass_port_select_in = 3'h0;
  logic [3:0] wstrb_in = 4'hf;
  logic lsp_reset_n_in = 1'b1, toe_n_in = 1'b1, bypass_route_en_n_in = 1'b1;
  logic [5:0] local_port_tdi_in = 6'h00;
  logic upstream_tck_in, upstream_tms_in, upstream_tdi_in, upstream_trst_n_in, upstream_tdo_out;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, upstream_tdo_oe_n_out;
  logic gateway_chosen_n_out, local_enable_n_out, self_test_n_out;
  logic [1:0] bresp_out, rresp_out;
  logic [31:0] rdata_out;
  sgpc_pkg::sgpc_port_s [5:0] local_port_out;
  logic [5:0] local_port_oe_n_out, port_debug_enable_n_out;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  sgpc_gateway DUT (.sys_clk_in, .reset_in, .ce_in, .awvalid_in, .awready_out, .awaddr_in,
    .awprot_in, .wvalid_in, .wready_out, .wdata_in, .wstrb_in, .bvalid_out, .bready_in,
    .bresp_out, .arvalid_in, .arready_out, .araddr_in, .arprot_in, .rvalid_out, .rready_in,
    .rdata_out, .rresp_out, .upstream_tck_in, .upstream_tms_in, .upstream_tdi_in,
    .upstream_trst_n_in, .upstream_tdo_out, .upstream_tdo_oe_n_out, .lsp_reset_n_in, .toe_n_in,
    .bypass_route_en_n_in, .bypass_port_select_in, .board_status_in, .gateway_chosen_n_out,
    .local_enable_n_out, .self_test_n_out, .local_port_out, .local_port_oe_n_out,
    .local_port_tdi_in, .port_debug_enable_n_out);
  sgpc_scan_master u_master (.tck_out(upstream_tck_in), .tms_out(upstream_tms_in),
    .tdi_out(upstream_tdi_in), .trst_n_out(upstream_trst_n_in),
    .tdo_in(upstream_tdo_oe_n_out ? 1'b1 : upstream_tdo_out)); // pulled up when released
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while (bvalid_out !== 1'b1);
    chk(bresp_out, sgpc_pkg::RESP_OKAY);
    bready_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do
    begin
      @(posedge sys_clk_in);
      if (arready_out) arvalid_in <= 1'b0;
    end while (rvalid_out !== 1'b1);
    d = rdata_out;
    r = rresp_out;
    rready_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic t_idle();
    logic [31:0] d;
    logic [1:0] r;
    chk(gateway_chosen_n_out, 1);
    chk(local_enable_n_out, 1);
    chk(self_test_n_out, 1);
    chk(port_debug_enable_n_out, 6'h3f);
    chk(upstream_tdo_oe_n_out, 1);
    axr(8'h10, d, r);
    chk(r, sgpc_pkg::RESP_SLVERR);
    chk(d, 0);
  endtask
  // select, then read board status over the scan bus and the register bus
  task automatic t_scan();
    logic [7:0] v;
    logic [31:0] d;
    logic [1:0] r;
    axw(sgpc_pkg::CTRL_OFFSET, 32'h1);
    repeat (2) @(posedge sys_clk_in);
    chk(gateway_chosen_n_out, 0);
    chk(local_enable_n_out, 0);
    chk(upstream_tdo_oe_n_out, 0);
    for (int i = 0; i < 2; i++)
    begin
      board_status_in <= i ? 8'h3c : 8'ha5;
      repeat (4) @(posedge sys_clk_in);
      u_master.read_status(v);
      @(posedge sys_clk_in);
      chk(v, i ? 8'h3c : 8'ha5);
      axr(sgpc_pkg::STATUS_OFFSET, d, r);
      chk(r, sgpc_pkg::RESP_OKAY);
      chk(d, {23'h000000, 1'b1, i ? 8'h3c : 8'ha5});
    end
    axw(sgpc_pkg::CTRL_OFFSET, 32'h0);
    repeat (3) @(posedge sys_clk_in);
    chk(upstream_tdo_oe_n_out, 1);
  endtask
  // one pulse per command, pin high between commands
  task automatic t_selftest();
    int n;
    repeat (2)
    begin
      axw(sgpc_pkg::CTRL_OFFSET, 32'h2);
      chk(self_test_n_out, 0);
      n = 0;
      while (self_test_n_out !== 1'b1 && n < 200)
      begin
        @(posedge sys_clk_in);
        n++;
      end
      repeat (20) @(posedge sys_clk_in);
      chk(self_test_n_out, 1);
    end
  endtask
  // local reset while selected: deselect and pulse trst low, timed on ports 0 and 5
  task automatic t_lsp();
    int n;
    axw(sgpc_pkg::CTRL_OFFSET, 32'h1);
    lsp_reset_n_in <= 1'b0;
    n = 0;
    while (local_port_oe_n_out !== 6'h00 && n < 10)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    lsp_reset_n_in <= 1'b1;
    n = 0;
    while (local_port_oe_n_out === 6'h00 && local_port_out[0].trst_n === 1'b0 &&
      local_port_out[5].trst_n === 1'b0 && n < 200)
    begin
      n++;
      @(posedge sys_clk_in);
    end
    chk(n, sgpc_pkg::TRST_PULSE_CYC);
    chk(gateway_chosen_n_out, 1);
    chk(local_port_oe_n_out, 6'h3f);
  endtask
  // every select code, then output disable, then bypass off
  task automatic t_bypass();
    logic [5:0] m;
    logic [7:0] v;
    for (int c = 0; c < 8; c++)
    begin
      bypass_route_en_n_in <= 1'b0;
      bypass_port_select_in <= c[2:0];
      local_port_tdi_in <= ~(6'h01 << c);
      repeat (4) @(posedge sys_clk_in);
      if (c == 2)
      begin
        u_master.read_status(v);
        @(posedge sys_clk_in);
        chk(v, 8'h00);
      end
      m = (c < 6) ? ~(6'h01 << c) : 6'h3f;
      chk(port_debug_enable_n_out, m);
      chk(local_port_oe_n_out, m);
      if (c < 6) chk(upstream_tdo_out, 0);
    end
    bypass_port_select_in <= 3'h2;
    toe_n_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    chk(local_port_oe_n_out, 6'h3f);
    toe_n_in <= 1'b1;
    bypass_route_en_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk(port_debug_enable_n_out, 6'h3f);
    chk(local_port_oe_n_out, 6'h3f);
  endtask
  // hang guard, far above the thousand or so cycles the run needs
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    t_idle();
    t_scan();
    t_selftest();
    t_lsp();
    t_bypass();
    end_sim();
  end
endmodule
